// ---- shared/uart_ctl_consts.svh ----
/*
  Offsets, field positions, reset values and timing counts for the
  two-channel serial control block. Assumes a 100 MHz system clock.
*/
`ifndef UART_CTL_CONSTS_SVH
`define UART_CTL_CONSTS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define CH0_MAIN_CONTROL_ADDR 32'h44400004
`define CH0_FIFO_CONTROL_ADDR 32'h44400008
`define CH0_MODEM_CONTROL_ADDR 32'h4440000C
`define CH1_MAIN_CONTROL_ADDR 32'h44404004
`define CH1_FIFO_CONTROL_ADDR 32'h44404008
`define CH1_MODEM_CONTROL_ADDR 32'h4440400C
`define CH_STATUS_OFFSET 32'h00000020
`define CH_ADDR_STRIDE 32'h00004000
`define CH0_BASE_ADDR 32'h44400000

// ----------------------------------------
// main control fields
// ----------------------------------------
`define MC_CLK_SEL_BIT 10
`define MC_TX_LEVEL_BIT 9
`define MC_RX_LEVEL_BIT 8
`define MC_TIMEOUT_EN_BIT 7
`define MC_ERR_INT_EN_BIT 6
`define MC_LOOPBACK_BIT 5
`define MC_BREAK_BIT 4
`define MC_TX_MODE_HI 3
`define MC_TX_MODE_LO 2
`define MC_RX_MODE_HI 1
`define MC_RX_MODE_LO 0
`define MAIN_CONTROL_RESET 11'h000

// ----------------------------------------
// fifo control fields
// ----------------------------------------
`define FC_TX_TRIG_HI 7
`define FC_TX_TRIG_LO 6
`define FC_RX_TRIG_HI 5
`define FC_RX_TRIG_LO 4
`define FC_TX_RESET_BIT 2
`define FC_RX_RESET_BIT 1
`define FC_FIFO_EN_BIT 0
`define FIFO_CONTROL_RESET 8'h00
`define FIFO_CONTROL_MASK 8'hF7

// ----------------------------------------
// modem control fields
// ----------------------------------------
`define MD_AUTO_FLOW_BIT 4
`define MD_RTS_BIT 0
`define MODEM_CONTROL_RESET 8'h00
`define MODEM_CONTROL_MASK 8'h11

// ----------------------------------------
// timing
// ----------------------------------------
`define CHAR_TIMES_TIMEOUT 3
`define FIFO_DEPTH 64

`endif

// ---- shared/uart_ctl_pkg.sv ----
/*
  Types for the serial control block. Assumes the consts header alongside.
*/
package uart_ctl_pkg;
  typedef enum logic [1:0] {SVC_OFF, SVC_POLL, SVC_DMA_A, SVC_DMA_B} service_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_BREAK} tx_state_t;
  typedef logic [10:0] main_control_t;
  typedef logic [7:0] byte_reg_t;
endpackage : uart_ctl_pkg

// ---- hw/uart_ctl_channel.sv ----
/*
  One serial channel's control logic: interrupt styling, timeout,
  break timing, loop-back mux, flow control and service routing.
  Assumes the line-side datapath reports its events as one-cycle pulses
  and its fifo levels as counts; all inputs synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_consts.svh"

module uart_ctl_channel #(
  parameter logic CHANNEL_ONE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration
  input wire uart_ctl_pkg::main_control_t mainControl,
  input wire uart_ctl_pkg::byte_reg_t fifoControl,
  input wire uart_ctl_pkg::byte_reg_t modemControl,
  // datapath status
  input wire logic txBufEmpty,
  input wire logic rxBufFull,
  input wire logic [6:0] txCount,
  input wire logic [6:0] rxCount,
  input wire logic rxCharDone,
  input wire logic overrunEvent,
  input wire logic charTick,
  input wire logic txShiftIdle,
  input wire logic txSerial,
  input wire logic rxPin,
  input wire logic clearToSendN,
  // outputs
  output logic txIrq,
  output logic rxIrq,
  output logic errIrq,
  output logic txPin,
  output logic rxSerial,
  output logic requestToSendN,
  output logic txStartOk,
  output logic breakDone,
  output logic [1:0] txDmaReq,
  output logic [1:0] rxDmaReq
);
  import uart_ctl_pkg::*;

  // ----------------------------------------
  // trigger decode
  // ----------------------------------------
  function automatic logic [6:0] rxTrigLevel(input logic [1:0] code);
    case (code)
      2'h0: rxTrigLevel = 7'h01;
      2'h1: rxTrigLevel = 7'h08;
      2'h2: rxTrigLevel = 7'h10;
      default: rxTrigLevel = 7'h20;
    endcase
  endfunction : rxTrigLevel

  function automatic logic [6:0] txTrigLevel(input logic [1:0] code);
    case (code)
      2'h0: txTrigLevel = 7'h00;
      2'h1: txTrigLevel = 7'h10;
      2'h2: txTrigLevel = 7'h20;
      default: txTrigLevel = 7'h30;
    endcase
  endfunction : txTrigLevel

  wire logic fifoOn = fifoControl[`FC_FIFO_EN_BIT];
  wire logic [1:0] txMode = mainControl[`MC_TX_MODE_HI:`MC_TX_MODE_LO];
  wire logic [1:0] rxMode = mainControl[`MC_RX_MODE_HI:`MC_RX_MODE_LO];
  wire logic txCond = fifoOn ? (txCount <= txTrigLevel(fifoControl[7:6])) : txBufEmpty;
  wire logic rxCond = fifoOn ? (rxCount >= rxTrigLevel(fifoControl[5:4])) : rxBufFull;
  // dma code valid only on its own channel
  wire logic txDmaSel = (txMode == (CHANNEL_ONE ? 2'h3 : 2'h2));
  wire logic rxDmaSel = (rxMode == (CHANNEL_ONE ? 2'h3 : 2'h2));
  wire logic txSvc = (txMode != 2'h0);
  wire logic rxSvc = (rxMode != 2'h0);

  logic txCond_reg, rxCond_reg;
  logic [1:0] silentChars_reg;
  logic timeoutHit_reg;
  logic breakActive_reg;

  // timeout: dma receive, fifo on, below trigger, three character times
  wire logic toArm = mainControl[`MC_TIMEOUT_EN_BIT] && fifoOn && rxDmaSel
    && !rxCond && (rxCount != 7'h00);
  wire logic toFire = toArm && charTick && !rxCharDone
    && (silentChars_reg == 2'(`CHAR_TIMES_TIMEOUT - 1)) && !timeoutHit_reg;

  // pulse style: rising edge of condition, one cycle
  wire logic txIrqNext = mainControl[`MC_TX_LEVEL_BIT] ? txCond
    : (txCond && !txCond_reg);
  wire logic rxIrqNext = (mainControl[`MC_RX_LEVEL_BIT] ? rxCond
    : (rxCond && !rxCond_reg)) || toFire;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      txCond_reg <= 1'b0;
      rxCond_reg <= 1'b0;
      txIrq <= 1'b0;
      rxIrq <= 1'b0;
      errIrq <= 1'b0;
      txDmaReq <= 2'h0;
      rxDmaReq <= 2'h0;
    end else begin
      txCond_reg <= txCond;
      rxCond_reg <= rxCond;
      txIrq <= txIrqNext && txSvc && !txDmaSel;
      rxIrq <= rxIrqNext && rxSvc;
      errIrq <= overrunEvent && mainControl[`MC_ERR_INT_EN_BIT];
      txDmaReq <= {txDmaSel && CHANNEL_ONE, txDmaSel && !CHANNEL_ONE} & {2{txCond}};
      rxDmaReq <= {rxDmaSel && CHANNEL_ONE, rxDmaSel && !CHANNEL_ONE} & {2{rxCond}};
    end
  end

  // ----------------------------------------
  // receive silence counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      silentChars_reg <= 2'h0;
      timeoutHit_reg <= 1'b0;
    end else if (rxCharDone || !toArm) begin
      silentChars_reg <= 2'h0;
      timeoutHit_reg <= 1'b0;
    end else if (charTick && !timeoutHit_reg) begin
      silentChars_reg <= toFire ? 2'h0 : silentChars_reg + 2'h1;
      timeoutHit_reg <= toFire;
    end
  end

  // ----------------------------------------
  // break: line low for one frame time
  // ----------------------------------------
  wire logic breakReq = mainControl[`MC_BREAK_BIT];
  always_ff @(posedge clk) begin
    if (!resetn) begin
      breakActive_reg <= 1'b0;
      breakDone <= 1'b0;
    end else begin
      breakDone <= 1'b0;
      // request bit is still set while its self-clear lands: no second break
      if (!breakActive_reg && breakReq && txShiftIdle && !breakDone) begin
        breakActive_reg <= 1'b1;
      end else if (breakActive_reg && charTick) begin
        breakActive_reg <= 1'b0;
        breakDone <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // pins, loop-back and flow control
  // ----------------------------------------
  wire logic loop = mainControl[`MC_LOOPBACK_BIT];
  wire logic lineOut = breakActive_reg ? 1'b0 : txSerial;
  wire logic autoFlow = modemControl[`MD_AUTO_FLOW_BIT];
  wire logic rxRoomLow = fifoOn ? (rxCount >= 7'(`FIFO_DEPTH - 1)) : rxBufFull;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txPin <= 1'b1;
      rxSerial <= 1'b1;
      requestToSendN <= 1'b1;
      txStartOk <= 1'b0;
    end else begin
      txPin <= loop ? 1'b1 : lineOut;
      rxSerial <= loop ? lineOut : rxPin;
      requestToSendN <= autoFlow ? rxRoomLow
        : !modemControl[`MD_RTS_BIT];
      txStartOk <= !breakActive_reg && !breakReq
        && (!autoFlow || !clearToSendN || loop);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  tx_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    (txIrq && !mainControl[`MC_TX_LEVEL_BIT] && $stable(mainControl)) |=> !txIrq)
    else $error("tx pulse longer than one cycle");
  rts_manual_a: assert property (@(posedge clk) disable iff (!resetn)
    (!modemControl[`MD_AUTO_FLOW_BIT] && $stable(modemControl))
    |=> (requestToSendN == !$past(modemControl[`MD_RTS_BIT])))
    else $error("manual rts level wrong");
  err_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    errIrq |-> $past(overrunEvent) && $past(mainControl[`MC_ERR_INT_EN_BIT]))
    else $error("error irq without cause");
  break_low_a: assert property (@(posedge clk) disable iff (!resetn)
    (breakActive_reg && !loop) |=> !txPin)
    else $error("line not low during break");
  loop_feed_a: assert property (@(posedge clk) disable iff (!resetn)
    loop |=> (txPin && rxSerial == $past(lineOut)))
    else $error("loop-back path wrong");
endmodule : uart_ctl_channel
`default_nettype wire

// ---- hw/uart_ctl_top.sv ----
/*
  Two-channel serial control block: AHB-Lite register slave for the main,
  fifo and modem control registers, and two channel control engines.
  Assumes a line-side datapath that reports events and fifo counts.
*/
// Design decision made here: the AHB-Lite register port.
// What this block does
// - Two independent channels, each with its own three control registers.
// - Main control bit 10 picks internal or external baud source.
// - Bit 9: transmit interrupt pulse at 0, level at 1.
// - Bit 8: receive interrupt pulse at 0, level at 1.
// - Bit 7 enables receive timeout, only with fifos, via receive interrupt.
// - DMA receive, below trigger, three silent character times raises timeout.
// - Bit 6 enables overrun error interrupt.
// - Bit 5 selects loop-back test mode.
// - Bit 4 sends one-frame break, then clears itself.
// - Bits 3:2 select transmit service: off, polled, or DMA.
// - Bits 1:0 select receive service: off, polled, or DMA.
// - Code 10 is DMA pair one on channel 0; 11 pair two on channel 1.
// - Fifo control 7:6 transmit trigger; 00 fires when empty.
// - Fifo control 5:4 receive trigger; 00 fires at one byte.
// - Fifo control bit 2 empties transmit fifo, then self-clears.
// - Fifo control bit 1 empties receive fifo, then self-clears.
// - Fifo control bit 0 enables fifo mode.
// - Modem bit 4 auto flow: hardware drives request-to-send itself.
// - Without auto flow, modem bit 0 drives request-to-send, active low.
// - Loop-back feeds transmit data into own receiver.
// - Outside loop-back, break holds transmit line low for one full frame.
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_consts.svh"

module uart_ctl_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // datapath status, per channel
  input wire logic [1:0] txBufEmpty,
  input wire logic [1:0] rxBufFull,
  input wire logic [13:0] txCount,
  input wire logic [13:0] rxCount,
  input wire logic [1:0] rxCharDone,
  input wire logic [1:0] overrunEvent,
  input wire logic [1:0] charTick,
  input wire logic [1:0] txShiftIdle,
  input wire logic [1:0] txSerial,
  // line pins
  input wire logic [1:0] rxPin,
  input wire logic [1:0] clearToSendN,
  output logic [1:0] txPin,
  output logic [1:0] requestToSendN,
  // to datapath
  output logic [1:0] rxSerial,
  output logic [1:0] txStartOk,
  output logic [1:0] baudSrcExternal,
  output logic [1:0] fifoEnable,
  output logic [1:0] txFifoFlush,
  output logic [1:0] rxFifoFlush,
  // interrupts and dma requests
  output logic [1:0] txIrq,
  output logic [1:0] rxIrq,
  output logic [1:0] errIrq,
  output logic [3:0] txDmaReq,
  output logic [3:0] rxDmaReq
);
  import uart_ctl_pkg::*;

  // ----------------------------------------
  // address phase capture
  // ----------------------------------------
  logic wrPend_reg;
  logic [31:0] wrAddr_reg;
  main_control_t mainControl_reg [2];
  byte_reg_t fifoControl_reg [2];
  byte_reg_t modemControl_reg [2];
  logic [1:0] breakDone;

  wire logic addrPhase = hsel && hready && htrans[1];
  wire logic [31:0] chOff = haddr & 32'h00000FFF;
  wire logic chSel = haddr[14];

  function automatic logic [1:0] regIndex(input logic [31:0] a);
    case (a & 32'h00000FFF)
      32'h00000004: regIndex = 2'h1;
      32'h00000008: regIndex = 2'h2;
      32'h0000000C: regIndex = 2'h3;
      default: regIndex = 2'h0;
    endcase
  endfunction : regIndex

  function automatic logic chHit(input logic [31:0] a);
    chHit = ((a & 32'hFFFFB000) == `CH0_BASE_ADDR);
  endfunction : chHit

  wire logic [1:0] rdIdx = chHit(haddr) ? regIndex(haddr) : 2'h0;
  wire logic [1:0] wrIdx = chHit(wrAddr_reg) ? regIndex(wrAddr_reg) : 2'h0;
  wire logic wrCh = wrAddr_reg[14];
  wire logic [31:0] rdValue =
      (rdIdx == 2'h1) ? {21'h0, mainControl_reg[chSel]}
    : (rdIdx == 2'h2) ? {24'h0, fifoControl_reg[chSel]}
    : (rdIdx == 2'h3) ? {24'h0, modemControl_reg[chSel]}
    : (chOff == `CH_STATUS_OFFSET && chHit(haddr))
      ? {26'h0, clearToSendN[chSel], requestToSendN[chSel], rxIrq[chSel],
         txIrq[chSel], txPin[chSel], txStartOk[chSel]}
    : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 32'h00000000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr;
      end
      if (addrPhase && !hwrite) begin
        hrdata <= rdValue;
      end
    end
  end

  // ----------------------------------------
  // per-channel control registers
  // ----------------------------------------
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      wire logic wrHere = wrPend_reg && (wrCh == 1'(c));
      always_ff @(posedge clk) begin
        if (!resetn) begin
          mainControl_reg[c] <= `MAIN_CONTROL_RESET;
          fifoControl_reg[c] <= `FIFO_CONTROL_RESET;
          modemControl_reg[c] <= `MODEM_CONTROL_RESET;
        end else begin
          if (wrHere && wrIdx == 2'h1) begin
            mainControl_reg[c] <= hwdata[10:0];
          end else if (breakDone[c]) begin
            mainControl_reg[c][`MC_BREAK_BIT] <= 1'b0;
          end
          if (wrHere && wrIdx == 2'h2) begin
            fifoControl_reg[c] <= hwdata[7:0] & `FIFO_CONTROL_MASK;
          end else begin
            // flush strobes last one cycle
            fifoControl_reg[c][`FC_TX_RESET_BIT] <= 1'b0;
            fifoControl_reg[c][`FC_RX_RESET_BIT] <= 1'b0;
          end
          if (wrHere && wrIdx == 2'h3) begin
            // reserved bits held at zero
            modemControl_reg[c] <= hwdata[7:0] & `MODEM_CONTROL_MASK;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!resetn) begin
          baudSrcExternal[c] <= 1'b0;
          fifoEnable[c] <= 1'b0;
          txFifoFlush[c] <= 1'b0;
          rxFifoFlush[c] <= 1'b0;
        end else begin
          baudSrcExternal[c] <= mainControl_reg[c][`MC_CLK_SEL_BIT];
          fifoEnable[c] <= fifoControl_reg[c][`FC_FIFO_EN_BIT];
          txFifoFlush[c] <= fifoControl_reg[c][`FC_TX_RESET_BIT];
          rxFifoFlush[c] <= fifoControl_reg[c][`FC_RX_RESET_BIT];
        end
      end

      uart_ctl_channel #(.CHANNEL_ONE(1'(c))) u_chan (
        .clk(clk),
        .resetn(resetn),
        .mainControl(mainControl_reg[c]),
        .fifoControl(fifoControl_reg[c]),
        .modemControl(modemControl_reg[c]),
        .txBufEmpty(txBufEmpty[c]),
        .rxBufFull(rxBufFull[c]),
        .txCount(txCount[c*7 +: 7]),
        .rxCount(rxCount[c*7 +: 7]),
        .rxCharDone(rxCharDone[c]),
        .overrunEvent(overrunEvent[c]),
        .charTick(charTick[c]),
        .txShiftIdle(txShiftIdle[c]),
        .txSerial(txSerial[c]),
        .rxPin(rxPin[c]),
        .clearToSendN(clearToSendN[c]),
        .txIrq(txIrq[c]),
        .rxIrq(rxIrq[c]),
        .errIrq(errIrq[c]),
        .txPin(txPin[c]),
        .rxSerial(rxSerial[c]),
        .requestToSendN(requestToSendN[c]),
        .txStartOk(txStartOk[c]),
        .breakDone(breakDone[c]),
        .txDmaReq(txDmaReq[c*2 +: 2]),
        .rxDmaReq(rxDmaReq[c*2 +: 2])
      );
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  flush_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    fifoControl_reg[0][`FC_TX_RESET_BIT] |=> !fifoControl_reg[0][`FC_TX_RESET_BIT]
      || $past(wrPend_reg))
    else $error("tx flush bit stuck");
  modem_rsvd_a: assert property (@(posedge clk) disable iff (!resetn)
    (modemControl_reg[1] & 8'hEE) == 8'h00)
    else $error("reserved modem bits set");
  ahb_ready_a: assert property (@(posedge clk) disable iff (!resetn)
    hreadyout && !hresp)
    else $error("slave stalled or errored");
endmodule : uart_ctl_top
`default_nettype wire

// ---- tb/remote_dev.sv ----
/*
  Remote serial device model: sends one 8N1 frame on its line on request,
  and holds its clear-to-send output as the bench asks.
  Assumes it shares the block's clock; the line idles high.
*/
`timescale 1ns/1ps
`default_nettype none

module remote_dev #(
  parameter int BIT = 8, // clocks per bit, the rate the divisor would set
  parameter logic [7:0] DATA = 8'hA5
) (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic go,
  input wire logic ctsOff,
  // line side
  output logic rxLine = 1'h1,
  output logic ctsN
);
  logic [9:0] frame;
  int n;

  // active low: low lets the block start characters
  assign ctsN = ctsOff;

  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  // go is only looked at between frames, so a frame is never cut short
  always @(posedge clk) begin
    if (go === 1'h1) begin
      frame = {1'h1, DATA, 1'h0};
      for (n = 0; n < 10 * BIT; n++) begin
        rxLine <= frame[n / BIT];
        @(posedge clk);
      end
      rxLine <= 1'h1;
    end
  end
endmodule : remote_dev

`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the two-channel serial control block.
  Assumes the consts header on the include path and the remote model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_consts.svh"

module testbench;
  import uart_ctl_pkg::*;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  localparam logic [31:0] M0 = `CH0_MAIN_CONTROL_ADDR;
  localparam logic [31:0] F0 = `CH0_FIFO_CONTROL_ADDR;
  localparam logic [31:0] D0 = `CH0_MODEM_CONTROL_ADDR;
  localparam logic [31:0] M1 = `CH1_MAIN_CONTROL_ADDR;
  localparam logic [31:0] F1 = `CH1_FIFO_CONTROL_ADDR;
  localparam logic [31:0] D1 = `CH1_MODEM_CONTROL_ADDR;
  localparam logic [31:0] REGS [6] = '{M0, F0, D0, M1, F1, D1};
  logic clk = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, go = 1'h0, ctsOff = 1'h0;
  logic [1:0] htrans = 2'h0, txE = 2'h0, rxF = 2'h0, ovr = 2'h0, tick = 2'h0;
  logic [1:0] rxD = 2'h0, idle = 2'h0, txS = 2'h3;
  logic [13:0] txC = 14'h0, rxC = 14'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [7:0] b;
  int bad_count = 0, total_checks = 0, rxHits = 0, errHits = 0, flHits = 0, txHits = 0, k;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, rxLine, ctsN;
  wire logic [1:0] txPin, rts, rxSerial, txOk, baudExt, fifoEn, txFl, rxFl, txIrq, rxIrq, errIrq;
  wire logic [3:0] txDma, rxDma;

  always #5 clk = ~clk;

  uart_ctl_top dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txBufEmpty(txE), .rxBufFull(rxF), .txCount(txC),
    .rxCount(rxC), .rxCharDone(rxD), .overrunEvent(ovr), .charTick(tick), .txShiftIdle(idle),
    .txSerial(txS), .rxPin({1'h1, rxLine}), .clearToSendN({1'h0, ctsN}), .txPin(txPin),
    .requestToSendN(rts), .rxSerial(rxSerial), .txStartOk(txOk), .baudSrcExternal(baudExt),
    .fifoEnable(fifoEn), .txFifoFlush(txFl), .rxFifoFlush(rxFl), .txIrq(txIrq), .rxIrq(rxIrq),
    .errIrq(errIrq), .txDmaReq(txDma), .rxDmaReq(rxDma));

  remote_dev #(.BIT(8), .DATA(8'hA5)) far (.clk(clk), .go(go), .ctsOff(ctsOff),
    .rxLine(rxLine), .ctsN(ctsN));

  // pulse counters; x never counts as a hit
  always @(posedge clk) begin
    if (txIrq[0] === 1'h1) txHits++;
    if (rxIrq[0] === 1'h1) rxHits++;
    if (errIrq[0] === 1'h1) errHits++;
    if (txFl[1] === 1'h1) flHits++;
    if (rxFl[1] === 1'h1) flHits += 16;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rst();
    resetn <= 1'h0;
    cyc(4);
    resetn <= 1'h1;
  endtask : rst

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0);
    chk(rd, e);
    chk(hresp, 1'h0);
  endtask : rdchk

  task automatic strobe(input logic isTick);
    if (isTick) tick <= 2'h1;
    else ovr <= 2'h1;
    cyc(1);
    tick <= 2'h0;
    ovr <= 2'h0;
    cyc(4);
  endtask : strobe

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rst();
    for (k = 0; k < 6; k++) rdchk(REGS[k], 32'h0);
    wr(32'h44400040, 32'hFF);
    rdchk(32'h44400040, 32'h0);
    wr(M0, 32'h7EF);
    wr(F0, 32'hFF);
    wr(D0, 32'h11);
    rdchk(M0, 32'h7EF);
    rdchk(F0, 32'hF1);
    rdchk(D0, 32'h11);
    for (k = 3; k < 6; k++) rdchk(REGS[k], 32'h0);
    chk(baudExt, 2'h1);
    chk(fifoEn, 2'h1);
  endtask : t_regs

  task automatic t_irq();
    rst();
    wr(M0, 32'h5);
    txE <= 2'h1;
    rxF <= 2'h1;
    txHits = 0;
    rxHits = 0;
    cyc(8);
    chk(txHits, 1);
    chk(rxHits, 1);
    wr(M0, 32'h305);
    cyc(3);
    chk({txIrq[0], rxIrq[0]}, 2'h3);
    txE <= 2'h0;
    rxF <= 2'h0;
    cyc(3);
    chk({txIrq[0], rxIrq[0]}, 2'h0);
  endtask : t_irq

  task automatic t_err();
    rst();
    wr(M0, 32'h45);
    errHits = 0;
    strobe(1'h0);
    chk(errHits != 0, 1);
    wr(M0, 32'h5);
    errHits = 0;
    strobe(1'h0);
    chk(errHits, 0);
  endtask : t_err

  task automatic t_timeout();
    rst();
    wr(F0, 32'h11);
    wr(M0, 32'h82);
    rxC <= 14'h3;
    rxHits = 0;
    repeat (2) strobe(1'h1);
    chk(rxHits, 0);
    strobe(1'h1);
    chk(rxHits, 1);
    rxC <= 14'h0;
    wr(M0, 32'h2);
    rxC <= 14'h3;
    rxHits = 0;
    repeat (4) strobe(1'h1);
    chk(rxHits, 0);
  endtask : t_timeout

  task automatic t_trig();
    rst();
    wr(F0, 32'h1);
    wr(M0, 32'h305);
    rxC <= 14'h1;
    cyc(3);
    chk({txIrq[0], rxIrq[0]}, 2'h3);
    rxC <= 14'h0;
    txC <= 14'h5;
    cyc(3);
    chk({txIrq[0], rxIrq[0]}, 2'h0);
  endtask : t_trig

  task automatic t_flush();
    rst();
    flHits = 0;
    wr(F1, 32'h7);
    cyc(4);
    chk(flHits, 17);
    rdchk(F1, 32'h1);
    chk(fifoEn, 2'h2);
  endtask : t_flush

  task automatic t_flow();
    rst();
    wr(D1, 32'h1);
    cyc(2);
    chk(rts[1], 1'h0);
    wr(D1, 32'h0);
    cyc(2);
    chk(rts[1], 1'h1);
    wr(F1, 32'h1);
    wr(D1, 32'h10);
    rxC <= 14'h1F80;
    cyc(3);
    chk(rts[1], 1'h1);
    rxC <= 14'h500;
    cyc(3);
    chk(rts[1], 1'h0);
    wr(M0, 32'h4);
    wr(D0, 32'h10);
    idle <= 2'h3;
    ctsOff <= 1'h1;
    cyc(3);
    chk(txOk[0], 1'h0);
    ctsOff <= 1'h0;
    cyc(3);
    chk(txOk[0], 1'h1);
    rdchk(`CH0_BASE_ADDR + `CH_STATUS_OFFSET, 32'h3);
  endtask : t_flow

  task automatic t_loop();
    rst();
    go <= 1'h1;
    cyc(1);
    go <= 1'h0;
    k = 0;
    while (rxSerial[0] !== 1'h0 && k < 50) begin
      cyc(1);
      k++;
    end
    cyc(4);
    for (k = 0; k < 8; k++) begin
      cyc(8);
      b[k] = rxSerial[0];
    end
    chk(b, 8'hA5);
    txS <= 2'h2;
    cyc(3);
    chk({txPin[0], rxSerial[0]}, 2'h1);
    wr(M0, 32'h20);
    cyc(3);
    chk({txPin[0], rxSerial[0]}, 2'h2);
    txS <= 2'h3;
  endtask : t_loop

  task automatic t_break();
    rst();
    idle <= 2'h1;
    wr(M0, 32'h10);
    cyc(3);
    chk(txPin[0], 1'h0);
    cyc(15);
    chk(txPin[0], 1'h0);
    strobe(1'h1);
    chk(txPin[0], 1'h1);
    rdchk(M0, 32'h0);
  endtask : t_break

  task automatic t_dma();
    rst();
    txE <= 2'h3;
    rxF <= 2'h3;
    for (k = 0; k < 4; k++) begin
      wr(M0, k * 5);
      wr(M1, k * 5);
      cyc(3);
      chk(txDma, {k == 3, 2'h0, k == 2});
      chk(rxDma, {k == 3, 2'h0, k == 2});
    end
  endtask : t_dma

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // each scenario starts from its own four-cycle reset
  initial begin
    t_regs();
    t_irq();
    t_err();
    t_timeout();
    t_trig();
    t_flush();
    t_flow();
    t_loop();
    t_break();
    t_dma();
    tally_and_finish();
  end

  // all scenarios take a few hundred cycles; 50k means a hang
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
